// *** dv/sccr_env_model.sv ***
// Oscillator and supply model for the clock and reset block
`default_nettype none
module sccr_env_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] oscEn,
  output logic [3:0] oscLvl,
  output logic sup1v1,
  output logic supReg,
  output logic supLvr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tick_q;
  logic [4:0] ph_q;
  // ----------------------------------------
  // Supply ramp and oscillators
  // ----------------------------------------
  assign sup1v1 = tick_q > 8'h02;
  assign supReg = tick_q > 8'h05;
  assign supLvr = tick_q > 8'h28;
  // Stopped oscillator sticks high, so a switch onto it stalls
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_q <= 8'h00;
      ph_q <= 5'h00;
      oscLvl <= 4'hF;
    end
    else
    begin
      if (tick_q != 8'hFF)
        tick_q <= tick_q + 8'h01;
      ph_q <= (ph_q == 5'h17) ? 5'h00 : ph_q + 5'h01;
      oscLvl[0] <= !oscEn[0] || (ph_q % 5'h06 < 5'h03);
      oscLvl[1] <= !oscEn[1] || (ph_q % 5'h04 < 5'h02);
      oscLvl[2] <= !oscEn[2] || (ph_q % 5'h08 < 5'h04);
      oscLvl[3] <= !oscEn[3] || ph_q[0];
    end
  end
endmodule : sccr_env_model
`default_nettype wire

// *** dv/sccr_top_chk.sv ***
// Checker for the clock and reset control block ports
`default_nettype none
module sccr_top_chk #(
  parameter int KCH = 7
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic stopMode,
  input wire logic idleMode,
  input wire logic externalResetPinN,
  input wire logic crystalEn,
  input wire logic pllEn,
  input wire logic fastOscEn,
  input wire logic pllSrcFast,
  input wire logic mainClkLvl,
  input wire logic freeRunningCoreClockEn,
  input wire logic coreBusClkEn,
  input wire logic [31:0] periphClkEn,
  input wire logic [31:0] periphRegReadEn,
  input wire logic [KCH-1:0] kernelTick,
  input wire logic bootRelease,
  input wire logic warmRstN,
  input wire logic [31:0] periphRstN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_pinLow;
    !externalResetPinN && bootRelease;
  endsequence
  sequence s_warmOn;
    ##[1:3] !warmRstN;
  endsequence
  property p_free_running_core_clock;
    freeRunningCoreClockEn == !stopMode;
  endproperty
  property p_hclk;
    coreBusClkEn == (!stopMode && !idleMode);
  endproperty
  property p_pstop;
    stopMode |-> periphClkEn == 32'h0000_0000;
  endproperty
  property p_pread;
    periphRegReadEn == periphClkEn;
  endproperty
  property p_boot;
    !bootRelease |=> !warmRstN;
  endproperty
  property p_prst;
    warmRstN |-> periphRstN == 32'hFFFF_FFFF;
  endproperty
  property p_tick;
    (kernelTick & $past(kernelTick)) == '0;
  endproperty
  property p_stop;
    $rose(stopMode) |-> ##[1:2] !(crystalEn || pllEn || fastOscEn || pllSrcFast);
  endproperty
  property p_pin;
    s_pinLow |-> s_warmOn;
  endproperty
  property p_glitch;
    $changed(mainClkLvl) |=> $stable(mainClkLvl);
  endproperty
  a_free_running_core_clock: assert property (p_free_running_core_clock) else $error("free clock enable wrong");
  a_hclk: assert property (p_hclk) else $error("core bus clock enable wrong");
  a_pstop: assert property (p_pstop) else $error("peripheral clock runs in stop");
  a_pread: assert property (p_pread) else $error("read enable differs from gate");
  a_boot: assert property (p_boot) else $error("warm reset released before boot");
  a_prst: assert property (p_prst) else $error("peripheral reset outside warm reset");
  a_tick: assert property (p_tick) else $error("kernel tick longer than one cycle");
  a_stop: assert property (p_stop) else $error("sources kept on at stop entry");
  a_pin: assert property (p_pin) else $error("pin reset gave no warm reset");
  a_glitch: assert property (p_glitch) else $error("runt phase on main clock");
endmodule : sccr_top_chk
bind sccr_top sccr_top_chk #(.KCH(KCH)) u_chk (.sys_clk(sys_clk), .rstn(rstn), .stopMode(stopMode),
  .idleMode(idleMode), .externalResetPinN(externalResetPinN), .crystalEn(crystalEn), .pllEn(pllEn),
  .fastOscEn(fastOscEn), .pllSrcFast(pllSrcFast), .mainClkLvl(mainClkLvl),
  .freeRunningCoreClockEn(freeRunningCoreClockEn), .coreBusClkEn(coreBusClkEn), .periphClkEn(periphClkEn),
  .periphRegReadEn(periphRegReadEn), .kernelTick(kernelTick), .bootRelease(bootRelease),
  .warmRstN(warmRstN), .periphRstN(periphRstN));
`default_nettype wire

// *** dv/sccr_top_tb.sv ***
// Testbench for the clock and reset control block
`default_nettype none
module sccr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, regWr, regRd, bootRelease, warmRstN, lowVoltageIrq, mainClkLvl;
  logic stopMode, idleMode, pinN, lvEvt, freeEn, coreEn, pllSrcFast, wdReq, cpuReq;
  logic sup1v1, supReg, supLvr;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, pClkEn, pRdEn, periphRstN, d;
  logic [3:0] oscEn, oscLvl;
  logic [1:0] coreDivSel;
  logic [6:0] kernelTick;
  int miscompares, n_checks, i, n;
  logic [7:0] ra [10] = '{8'h18, 8'h1C, 8'h20, 8'h30, 8'h40, 8'h44, 8'h90, 8'h94, 8'hA8, 8'h04};
  logic [31:0] re [10] = '{32'hD1, 32'h101, 32'h30FF_6F5F, 32'h6F0F, 32'h20, 32'h0, 32'h1_0000, 32'h0,
    32'h1_0000, 32'h0};
  sccr_top #(.INIT_CYC(20), .SYNC_CYC(10)) dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .supplyAbove1v1(sup1v1),
    .regulatorStable(supReg), .supplyAboveLvr(supLvr), .slowOscLvl(oscLvl[0]), .fastOscLvl(oscLvl[1]),
    .crystalLvl(oscLvl[2]), .pllLvl(oscLvl[3]), .externalResetPinN(pinN), .lowVoltageEvt(lvEvt),
    .watchdogRstReq(wdReq), .mainClkFail(1'b0), .crystalFail(1'b0), .cpuRstReq(cpuReq), .stopMode(stopMode),
    .idleMode(idleMode), .slowOscEn(oscEn[0]), .fastOscEn(oscEn[1]), .crystalEn(oscEn[2]), .pllEn(oscEn[3]),
    .pllSrcFast(pllSrcFast), .mainClkLvl(mainClkLvl), .coreDivSel(coreDivSel), .freeRunningCoreClockEn(freeEn),
    .coreBusClkEn(coreEn), .periphClkEn(pClkEn), .periphRegReadEn(pRdEn), .kernelTick(kernelTick),
    .bootRelease(bootRelease), .warmRstN(warmRstN), .periphRstN(periphRstN), .lowVoltageIrq(lowVoltageIrq));
  sccr_env_model u_env (.sys_clk(sys_clk), .rstn(rstn), .oscEn(oscEn), .oscLvl(oscLvl), .sup1v1(sup1v1),
    .supReg(supReg), .supLvr(supLvr));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic msw(input logic [3:0] st);
    for (i = 0; i < 50 && d[3:0] !== st; i++)
      rd(8'hB0);
    tmo(d[3:0] === st);
    chk(d[3:0], st);
  endtask : msw
  task automatic boot;
    for (i = 0; i < 300 && warmRstN !== 1'b1; i++)
      @(posedge sys_clk);
    tmo(bootRelease & warmRstN);
  endtask : boot
  // ----------------------------------------
  // Clock and sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rstn, regWr, regRd, stopMode, idleMode, lvEvt, wdReq, cpuReq, regAddr, regWdata} = '0;
    pinN = 1'b1;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    boot();
    for (n = 0; n < 10; n++)
    begin
      rd(ra[n]);
      chk(d, re[n]);
    end
    chk(oscEn[0], 1'b1);
    wr(8'h40, 32'h25);
    #1 chk(oscEn[1], 1'b1);
    repeat (20) @(posedge sys_clk); // Crystal settles before use
    wr(8'h44, 32'h12); // Step main clock from slow to crystal at half rate
    msw(4'h2);
    chk(coreDivSel, 2'h1);
    wr(8'h44, 32'h1); // Both sources run before the switch
    msw(4'h1);
    chk(coreDivSel, 2'h0);
    wr(8'h94, 32'h402);
    n = 0;
    repeat (200)
    begin
      @(posedge sys_clk);
      #1 n = n + kernelTick[1];
    end
    chk(n >= 24 && n <= 26, 1'b1);
    idleMode <= 1'b1;
    wr(8'h30, 32'hA5);
    #1 chk({freeEn, coreEn}, 2'h2);
    chk(pClkEn, 32'hA5);
    chk(pRdEn, 32'hA5);
    idleMode <= 1'b0;
    wr(8'h70, 32'h0);
    lvEvt <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk({lowVoltageIrq, warmRstN}, 2'h3);
    lvEvt <= 1'b0;
    wr(8'h1C, 32'h1FF);
    rd(8'h1C);
    chk(d, 32'h0);
    wr(8'h08, 32'h1);
    wdReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk(warmRstN, 1'b1);
    wdReq <= 1'b0;
    pinN <= 1'b0;
    for (i = 0; i < 10 && warmRstN !== 1'b0; i++)
      @(posedge sys_clk);
    #1 tmo(warmRstN === 1'b0);
    chk(periphRstN, ~32'h30FF_6F5F);
    pinN <= 1'b1;
    boot();
    rd(8'h1C);
    chk(d[0], 1'b1);
    wr(8'h1C, 32'h1FF);
    cpuReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cpuReq <= 1'b0;
    boot();
    rd(8'h1C);
    chk(d, 32'h40);
    wr(8'h40, 32'h127);
    stopMode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk(pClkEn, 32'h0);
    chk(freeEn, 1'b0);
    chk({oscEn[3:1], pllSrcFast, oscEn[0]}, 5'h01);
    stopMode <= 1'b0;
    rd(8'h44);
    chk(d[1:0], 2'h0);
    wr(8'h40, 32'h24);
    wr(8'h44, 32'h3);
    repeat (60) @(posedge sys_clk);
    rd(8'hB0);
    chk({d[3:2] !== 2'h0, mainClkLvl}, 2'h2);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    boot();
    rd(8'hB0);
    chk(d[3:0], 4'h0);
    end_sim();
  end
endmodule : sccr_top_tb
`default_nettype wire

// *** verilog/sccr_pkg.sv ***
// Package: constants for the system clock and reset control block
`default_nettype none
package sccr_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_SWRST = 8'h08;
  localparam logic [7:0] OFF_RSTEN = 8'h18;
  localparam logic [7:0] OFF_RSTST = 8'h1C;
  localparam logic [7:0] OFF_PRST = 8'h20;
  localparam logic [7:0] OFF_PGATE = 8'h30;
  localparam logic [7:0] OFF_CSRC = 8'h40;
  localparam logic [7:0] OFF_MSEL = 8'h44;
  localparam logic [7:0] OFF_LVOPT = 8'h70;
  localparam logic [7:0] OFF_KSEL0 = 8'h90;
  localparam logic [7:0] OFF_STATE = 8'hB0;
  // Reset values
  localparam logic [7:0] RST_RSTEN = 8'hD1;
  localparam logic [8:0] RST_RSTST = 9'h101;
  localparam logic [31:0] RST_PRST = 32'h30FF_6F5F;
  localparam logic [31:0] RST_PGATE = 32'h0000_6F0F;
  localparam logic [8:0] RST_CSRC = 9'h020;
  localparam logic [2:0] RST_LVOPT = 3'h5;
  localparam logic [16:0] RST_KSEL_ON = 17'h1_0000;
  // Clock source control fields
  localparam int CS_XTAL = 0;
  localparam int CS_PLL = 1;
  localparam int CS_FAST = 2;
  localparam int CS_SLOW = 5;
  localparam int CS_PLLSRC = 8;
  // Main clock select field
  localparam int MS_LSB = 0;
  localparam int MS_DIV = 4;
  // Kernel select fields
  localparam int KS_DIV_LSB = 0;
  localparam int KS_SRC_LSB = 8;
  localparam int KS_PCLK = 16;
  // Reset source bit positions
  localparam int RS_PIN = 0;
  localparam int RS_LVR = 1;
  localparam int RS_WDOG = 2;
  localparam int RS_MFAIL = 3;
  localparam int RS_XFAIL = 4;
  localparam int RS_SW = 5;
  localparam int RS_CPU = 6;
  localparam int RS_POR = 8;
  // Source encodings
  typedef enum logic [1:0] {MSRC_SLOW = 2'h0, MSRC_FAST = 2'h1, MSRC_XTAL = 2'h2, MSRC_PLL = 2'h3} sccr_msrc_t;
  localparam logic [2:0] KSRC_MAIN = 3'h0;
  localparam logic [2:0] KSRC_PCLK = 3'h5;
  // Glitch-free switch states
  typedef enum logic [1:0] {SW_RUN = 2'h0, SW_DROP = 2'h1, SW_PICK = 2'h3} sccr_sw_t;
  // Cold reset sequence states
  typedef enum logic [2:0] {CS_WAITSUP = 3'h0, CS_REGWAIT = 3'h1, CS_LVRWAIT = 3'h3, CS_SYNCWAIT = 3'h2,
    CS_BOOT = 3'h6} sccr_cold_t;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int INIT_WAIT_US = 4250;
  localparam int SYNC_WAIT_US = 400;
  localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
  localparam int SYNC_WAIT_CYC = SYNC_WAIT_US * CLK_MHZ;
endpackage : sccr_pkg
`default_nettype wire

// *** verilog/sccr_top.sv ***
// Module: system clock selection, kernel clocks and reset control
//
// Overview of operation
// RL1 - Clock source switches never produce runt pulses
// RL2 - Software keeps both sources running when switching
// RL3 - Dead source stalls switch until reset
// RL4 - Kernel clock: five sources, divider 1-255
// RL5 - Free clock off only in stop; core idle-gated
// RL6 - Software keeps core clock at most 96MHz
// RL7 - Per-peripheral clock gates; gated registers unreadable
// RL8 - Peripheral clock stops in stop mode
// RL9 - Main clock defaults to slow oscillator
// RL10 - Fast oscillator enabled by source control bit
// RL11 - Software routes crystal pins, awaits stabilisation
// RL12 - Software steps slow, crystal, PLL with waits
// RL13 - Software sequence: wait 7, divide 2, restore
// RL14 - Software picks flash wait by frequency
// RL15 - Seven kernel selectors; some allow peripheral clock
// RL16 - Cold from power-on; warm from seven sources
// RL17 - Power-on at 1.1V starts slow oscillator
// RL18 - Init 4.25ms, release at LOW_VOLTAGE_RESET, 0.4ms sync
// RL19 - Warm sources enabled, occurrences recorded
// RL20 - Warm reset hits only unmasked peripherals
// RL21 - Low voltage gives reset or interrupt
// RL22 - Stop forces slow main, crystal PLL, sources off
// RL23 - Warm reset release synchronised to clock
// RL24 - Divider restarts on rewrite
`default_nettype none
module sccr_top #(
  parameter int KCH = 7,
  parameter logic [KCH-1:0] PCLK_OK = 7'b000_1101,
  parameter int INIT_CYC = sccr_pkg::INIT_WAIT_CYC,
  parameter int SYNC_CYC = sccr_pkg::SYNC_WAIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic supplyAbove1v1,
  input wire logic regulatorStable,
  input wire logic supplyAboveLvr,
  input wire logic slowOscLvl,
  input wire logic fastOscLvl,
  input wire logic crystalLvl,
  input wire logic pllLvl,
  input wire logic externalResetPinN,
  input wire logic lowVoltageEvt,
  input wire logic watchdogRstReq,
  input wire logic mainClkFail,
  input wire logic crystalFail,
  input wire logic cpuRstReq,
  input wire logic stopMode,
  input wire logic idleMode,
  output logic slowOscEn,
  output logic fastOscEn,
  output logic crystalEn,
  output logic pllEn,
  output logic pllSrcFast,
  output logic mainClkLvl,
  output logic [1:0] coreDivSel,
  output logic freeRunningCoreClockEn,
  output logic coreBusClkEn,
  output logic [31:0] periphClkEn,
  output logic [31:0] periphRegReadEn,
  output logic [KCH-1:0] kernelTick,
  output logic bootRelease,
  output logic warmRstN,
  output logic [31:0] periphRstN,
  output logic lowVoltageIrq
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] rstEn_q, rstEn_d;
  logic [8:0] rstSt_q, rstSt_d;
  logic [31:0] pRst_q, pRst_d, pGate_q, pGate_d;
  logic [8:0] cSrc_q, cSrc_d;
  logic [5:0] mSel_q, mSel_d;
  logic [2:0] lvOpt_q, lvOpt_d;
  logic [16:0] kSel_q [KCH], kSel_d [KCH];
  logic [31:0] rdata_q, rdata_d;
  logic swRst_q, swRst_d;
  logic [8:0] rstEvt;
  logic stop_q, stopEnter;
  sccr_pkg::sccr_sw_t mState_q, mState_d;
  logic [1:0] mCur_q, mCur_d;

  function automatic logic isKsel(input logic [7:0] a, input int ch);
    isKsel = (a == sccr_pkg::OFF_KSEL0 + 8'(4 * ch));
  endfunction : isKsel

  assign stopEnter = stopMode & ~stop_q;

  always_comb
  begin
    rstEn_d = rstEn_q;
    pRst_d = pRst_q;
    pGate_d = pGate_q;
    cSrc_d = cSrc_q;
    mSel_d = mSel_q;
    lvOpt_d = lvOpt_q;
    kSel_d = kSel_q;
    swRst_d = 1'b0;
    rstSt_d = rstSt_q;
    rdata_d = 32'h0000_0000;
    if (regWr)
    begin
      case (regAddr)
        sccr_pkg::OFF_SWRST: swRst_d = regWdata[0];
        sccr_pkg::OFF_RSTEN: rstEn_d = regWdata[7:0];
        sccr_pkg::OFF_RSTST: rstSt_d = rstSt_q & ~regWdata[8:0];
        sccr_pkg::OFF_PRST: pRst_d = regWdata;
        sccr_pkg::OFF_PGATE: pGate_d = regWdata;
        sccr_pkg::OFF_CSRC: cSrc_d = regWdata[8:0];
        sccr_pkg::OFF_MSEL: mSel_d = regWdata[5:0];
        sccr_pkg::OFF_LVOPT: lvOpt_d = regWdata[2:0];
        default: ;
      endcase
      for (int i = 0; i < KCH; i++)
      begin
        if (isKsel(regAddr, i))
          kSel_d[i] = regWdata[16:0];
      end
    end
    rstSt_d = rstSt_d | rstEvt; // [RL19]
    if (stopEnter)
    begin
      mSel_d[1:0] = sccr_pkg::MSRC_SLOW; // [RL22]
      cSrc_d[sccr_pkg::CS_PLLSRC] = 1'b0;
      cSrc_d[sccr_pkg::CS_XTAL] = 1'b0;
      cSrc_d[sccr_pkg::CS_PLL] = 1'b0;
      cSrc_d[sccr_pkg::CS_FAST] = 1'b0;
    end
    if (regRd)
    begin
      case (regAddr)
        sccr_pkg::OFF_RSTEN: rdata_d = {24'h00_0000, rstEn_q};
        sccr_pkg::OFF_RSTST: rdata_d = {23'h00_0000, rstSt_q};
        sccr_pkg::OFF_PRST: rdata_d = pRst_q;
        sccr_pkg::OFF_PGATE: rdata_d = pGate_q;
        sccr_pkg::OFF_CSRC: rdata_d = {23'h00_0000, cSrc_q};
        sccr_pkg::OFF_MSEL: rdata_d = {26'h000_0000, mSel_q};
        sccr_pkg::OFF_LVOPT: rdata_d = {29'h0000_0000, lvOpt_q};
        sccr_pkg::OFF_STATE: rdata_d = {28'h000_0000, mState_q, mCur_q};
        default: rdata_d = 32'h0000_0000;
      endcase
      for (int i = 0; i < KCH; i++)
      begin
        if (isKsel(regAddr, i))
          rdata_d = {15'h0000, kSel_q[i]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstEn_q <= sccr_pkg::RST_RSTEN;
      rstSt_q <= sccr_pkg::RST_RSTST;
      pRst_q <= sccr_pkg::RST_PRST;
      pGate_q <= sccr_pkg::RST_PGATE;
      cSrc_q <= sccr_pkg::RST_CSRC;
      mSel_q <= 6'h00; // [RL9]
      lvOpt_q <= sccr_pkg::RST_LVOPT;
      for (int i = 0; i < KCH; i++)
        kSel_q[i] <= (i == 0 || i == KCH - 1) ? sccr_pkg::RST_KSEL_ON : 17'h0_0000;
      rdata_q <= 32'h0000_0000;
      swRst_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else
    begin
      rstEn_q <= rstEn_d;
      rstSt_q <= rstSt_d;
      pRst_q <= pRst_d;
      pGate_q <= pGate_d;
      cSrc_q <= cSrc_d;
      mSel_q <= mSel_d;
      lvOpt_q <= lvOpt_d;
      kSel_q <= kSel_d;
      rdata_q <= rdata_d;
      swRst_q <= swRst_d;
      stop_q <= stopMode;
    end
  end

  assign regRdata = rdata_q;
  assign fastOscEn = cSrc_q[sccr_pkg::CS_FAST]; // [RL10]
  assign crystalEn = cSrc_q[sccr_pkg::CS_XTAL];
  assign pllEn = cSrc_q[sccr_pkg::CS_PLL];
  assign pllSrcFast = cSrc_q[sccr_pkg::CS_PLLSRC];
  assign coreDivSel = mSel_q[sccr_pkg::MS_DIV +: 2];
  assign freeRunningCoreClockEn = ~stopMode; // [RL5]
  assign coreBusClkEn = ~stopMode & ~idleMode; // [RL5]
  assign periphClkEn = pGate_q & {32{~stopMode}}; // [RL7] [RL8]
  assign periphRegReadEn = periphClkEn; // [RL7]

  // ----------------------------------------------------------------
  // Main clock glitch-free switch
  // ----------------------------------------------------------------
  logic mLvl_q, mLvl_d;
  logic [3:0] srcVec;
  assign srcVec = {pllLvl, crystalLvl, fastOscLvl, slowOscLvl};

  always_comb
  begin
    mState_d = mState_q;
    mCur_d = mCur_q;
    mLvl_d = 1'b0;
    case (mState_q)
      sccr_pkg::SW_RUN:
      begin
        mLvl_d = srcVec[mCur_q];
        if (mSel_q[sccr_pkg::MS_LSB +: 2] != mCur_q)
          mState_d = sccr_pkg::SW_DROP;
      end
      sccr_pkg::SW_DROP:
      begin
        mLvl_d = srcVec[mCur_q] & mLvl_q; // [RL1]
        if (!srcVec[mCur_q])
          mState_d = sccr_pkg::SW_PICK; // [RL3]
      end
      sccr_pkg::SW_PICK:
        if (!srcVec[mSel_q[1:0]])
        begin
          mCur_d = mSel_q[1:0]; // [RL1] [RL3]
          mState_d = sccr_pkg::SW_RUN;
        end
      default: mState_d = sccr_pkg::SW_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mState_q <= sccr_pkg::SW_RUN;
      mCur_q <= sccr_pkg::MSRC_SLOW; // [RL9]
      mLvl_q <= 1'b0;
    end
    else
    begin
      mState_q <= mState_d;
      mCur_q <= mCur_d;
      mLvl_q <= mLvl_d;
    end
  end
  assign mainClkLvl = mLvl_q;

  // ----------------------------------------------------------------
  // Kernel clock selectors and dividers
  // ----------------------------------------------------------------
  logic [5:0] kSrcVec;
  assign kSrcVec = {mLvl_q, fastOscLvl, slowOscLvl, pllLvl, crystalLvl, mLvl_q};

  genvar g;
  generate
    for (g = 0; g < KCH; g++)
    begin : gKern
      sccr_pkg::sccr_sw_t st_q, st_d;
      logic [2:0] cur_q, cur_d, req;
      logic [7:0] cnt_q, cnt_d, divN;
      logic prev_q, prev_d, tick_q, tick_d, lvl;
      assign req = (kSel_q[g][sccr_pkg::KS_PCLK] && PCLK_OK[g]) ? sccr_pkg::KSRC_PCLK
        : (kSel_q[g][sccr_pkg::KS_SRC_LSB +: 3] > 3'h4 ? sccr_pkg::KSRC_MAIN
        : kSel_q[g][sccr_pkg::KS_SRC_LSB +: 3]); // [RL4] [RL15]
      assign divN = (kSel_q[g][sccr_pkg::KS_DIV_LSB +: 8] == 8'h00) ? 8'h01
        : kSel_q[g][sccr_pkg::KS_DIV_LSB +: 8]; // [RL4]
      assign lvl = kSrcVec[cur_q];
      always_comb
      begin
        st_d = st_q;
        cur_d = cur_q;
        cnt_d = cnt_q;
        prev_d = lvl;
        tick_d = 1'b0;
        case (st_q)
          sccr_pkg::SW_RUN:
          begin
            if (lvl && !prev_q)
            begin
              if (cnt_q + 8'h01 >= divN)
              begin
                cnt_d = 8'h00;
                tick_d = 1'b1; // [RL4]
              end
              else
                cnt_d = cnt_q + 8'h01;
            end
            if (req != cur_q)
              st_d = sccr_pkg::SW_DROP;
          end
          sccr_pkg::SW_DROP:
            if (!lvl)
              st_d = sccr_pkg::SW_PICK; // [RL1] [RL3]
          sccr_pkg::SW_PICK:
          begin
            prev_d = 1'b0;
            if (!kSrcVec[req])
            begin
              cur_d = req;
              cnt_d = 8'h00;
              st_d = sccr_pkg::SW_RUN;
            end
          end
          default: st_d = sccr_pkg::SW_RUN;
        endcase
        if (regWr && isKsel(regAddr, g))
          cnt_d = 8'h00; // [RL24]
      end
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          st_q <= sccr_pkg::SW_RUN;
          cur_q <= sccr_pkg::KSRC_MAIN;
          cnt_q <= 8'h00;
          prev_q <= 1'b0;
          tick_q <= 1'b0;
        end
        else
        begin
          st_q <= st_d;
          cur_q <= cur_d;
          cnt_q <= cnt_d;
          prev_q <= prev_d;
          tick_q <= tick_d;
        end
      end
      assign kernelTick[g] = tick_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Cold reset sequence
  // ----------------------------------------------------------------
  sccr_pkg::sccr_cold_t cold_q, cold_d;
  logic [31:0] cCnt_q, cCnt_d;

  always_comb
  begin
    cold_d = cold_q;
    cCnt_d = cCnt_q;
    case (cold_q)
      sccr_pkg::CS_WAITSUP:
        if (supplyAbove1v1)
          cold_d = sccr_pkg::CS_REGWAIT; // [RL17]
      sccr_pkg::CS_REGWAIT:
        if (!regulatorStable)
          cCnt_d = 32'h0000_0000;
        else if (cCnt_q >= 32'(INIT_CYC - 1))
        begin
          cCnt_d = 32'h0000_0000;
          cold_d = sccr_pkg::CS_LVRWAIT; // [RL18]
        end
        else
          cCnt_d = cCnt_q + 32'h0000_0001;
      sccr_pkg::CS_LVRWAIT:
        if (supplyAboveLvr)
          cold_d = sccr_pkg::CS_SYNCWAIT; // [RL18]
      sccr_pkg::CS_SYNCWAIT:
        if (cCnt_q >= 32'(SYNC_CYC - 1))
          cold_d = sccr_pkg::CS_BOOT; // [RL18]
        else
          cCnt_d = cCnt_q + 32'h0000_0001;
      sccr_pkg::CS_BOOT: cold_d = sccr_pkg::CS_BOOT;
      default: cold_d = sccr_pkg::CS_WAITSUP;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cold_q <= sccr_pkg::CS_WAITSUP; // [RL16]
      cCnt_q <= 32'h0000_0000;
    end
    else
    begin
      cold_q <= cold_d;
      cCnt_q <= cCnt_d;
    end
  end
  assign bootRelease = (cold_q == sccr_pkg::CS_BOOT);
  assign slowOscEn = (cold_q != sccr_pkg::CS_WAITSUP) & cSrc_q[sccr_pkg::CS_SLOW]; // [RL17]

  // ----------------------------------------------------------------
  // Warm reset sources and release
  // ----------------------------------------------------------------
  logic [6:0] srcRaw;
  logic warmReq, rsync1_q, rsync2_q, lvIrq_q;
  assign srcRaw = {cpuRstReq, swRst_q, crystalFail, mainClkFail, watchdogRstReq,
    lowVoltageEvt & lvOpt_q[0], ~externalResetPinN}; // [RL16] [RL21]
  assign rstEvt = {2'b00, srcRaw & rstEn_q[6:0]}; // [RL19]
  assign warmReq = |rstEvt;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rsync1_q <= 1'b0;
      rsync2_q <= 1'b0;
      lvIrq_q <= 1'b0;
    end
    else
    begin
      rsync1_q <= ~warmReq & bootRelease; // [RL23]
      rsync2_q <= rsync1_q & ~warmReq; // [RL23]
      lvIrq_q <= lowVoltageEvt & ~lvOpt_q[0]; // [RL21]
    end
  end
  assign warmRstN = rsync2_q;
  assign periphRstN = ~(pRst_q & {32{~rsync2_q}}); // [RL20]
  assign lowVoltageIrq = lvIrq_q;

endmodule : sccr_top
`default_nettype wire
